// ---- rtl/art_pkg.sv ----
// Package with register map, field layout and trigger codes of the converter result and trigger logic.
package art_pkg;
   // ****************************************
   // Register addressing.
   // ****************************************
   localparam logic [7:0] IO_ADDR_MAX = 8'h3f;
   localparam logic [7:0] DATA_SPACE_OFFSET = 8'h20;
   localparam logic [7:0] DATA_SPACE_LIMIT = 8'h5f;
   localparam logic [5:0] RESULT_LOW_OFFSET = 6'h04;
   localparam logic [5:0] RESULT_HIGH_OFFSET = 6'h05;
   localparam logic [5:0] CTRL_STATUS_OFFSET = 6'h06;
   localparam logic [5:0] SPECIAL_FUNCTION_OFFSET = 6'h30;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [9:0] RESULT_RESET = 10'h000;
   // ****************************************
   // Field positions.
   // ****************************************
   localparam int CONV_EN_BIT = 7;
   localparam int START_BIT = 6;
   localparam int AUTO_TRIG_BIT = 5;
   localparam int DONE_FLAG_BIT = 4;
   localparam int IRQ_EN_BIT = 3;
   localparam int PRESCALE_MSB = 2;
   localparam int TRIG_SEL_MSB = 7;
   localparam int TRIG_SEL_LSB = 5;
   // ****************************************
   // Types.
   // ****************************************
   typedef enum logic [2:0] {
      TRIG_FREE_RUN = 3'h0,
      TRIG_ANALOG_CMP = 3'h1,
      TRIG_EXT_INT0 = 3'h2,
      TRIG_T0_COMPARE = 3'h3,
      TRIG_T0_OVERFLOW = 3'h4,
      TRIG_T1_COMPARE_B = 3'h5,
      TRIG_T1_OVERFLOW = 3'h6,
      TRIG_T1_CAPTURE = 3'h7
   } art_trig_src_t;

   typedef struct packed {
      logic analog_cmp;
      logic ext_int0;
      logic t0_compare;
      logic t0_overflow;
      logic t1_compare_b;
      logic t1_overflow;
      logic t1_capture;
   } art_trig_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic data_space;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } art_io_req_t;
endpackage : art_pkg

// ---- rtl/art_result_trigger.sv ----
// Result registers, control register and auto-trigger detection of the converter.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Right align: bits 9:8 in high low bits
// - Left align: bits 1:0 at low 7:6
// - Left align: bits 9:2 fill high register
// - Result registers read-only, reset zero
// - Trigger select bits 7:5 at 0x30
// - Trigger select ignored without auto trigger
// - Rising selected flag starts conversion
// - Switching to set source is an edge
// - Switching to free running never triggers
// - Eight trigger source codes decoded
// - IO offsets, data space plus 0x20
// - Low read freezes results until high read
// - Auto trigger enable arms triggering
// - Done flag set on result, one clears
// - Enable off aborts running conversion
module art_result_trigger
   import art_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset_n,
   // Register access port.
   input wire art_io_req_t io_req,
   output logic [7:0] io_rdata,
   // Control bit the result layout depends on.
   input wire logic left_align_select,
   // Trigger flags from other peripherals.
   input wire art_trig_flags_t trig_flags,
   // Converter core side.
   input wire logic conv_done,
   input wire logic [9:0] conv_result,
   output logic conv_start,
   output logic converter_enable,
   output logic conv_abort,
   output logic conv_busy,
   output logic [2:0] prescale_select,
   output logic irq_enable
);
   // ****************************************
   // Reset release.
   // ****************************************
   // Reset is applied at once and removed through two flip-flops so that its release is clean.
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // ****************************************
   // Address decode.
   // ****************************************
   // Data space accesses are moved down to the I/O offsets before decoding.
   function automatic logic [5:0] io_offset(input art_io_req_t r);
      logic [7:0] a;
      a = r.data_space ? r.addr - DATA_SPACE_OFFSET : r.addr;
      return a[5:0];
   endfunction : io_offset

   // Addresses outside either window are ignored.
   function automatic logic io_valid(input art_io_req_t r);
      logic ok;
      ok = r.data_space ? (r.addr >= DATA_SPACE_OFFSET && r.addr <= DATA_SPACE_LIMIT)
                        : (r.addr <= IO_ADDR_MAX);
      return ok;
   endfunction : io_valid

   // A register is addressed when its strobe is up, the address is in range and the offset matches.
   function automatic logic reg_hit(input logic strobe, input logic in_range, input logic [5:0] off,
                                    input logic [5:0] reg_off);
      logic h;
      h = strobe && in_range && off == reg_off;
      return h;
   endfunction : reg_hit

   logic [5:0] offset;
   logic hit;
   logic wr_ctrl;
   logic wr_sfr;
   logic rd_low;
   logic rd_high;
   assign offset = io_offset(io_req);
   assign hit = io_valid(io_req);
   assign wr_ctrl = reg_hit(io_req.wr, hit, offset, CTRL_STATUS_OFFSET);
   assign wr_sfr = reg_hit(io_req.wr, hit, offset, SPECIAL_FUNCTION_OFFSET);
   assign rd_low = reg_hit(io_req.rd, hit, offset, RESULT_LOW_OFFSET);
   assign rd_high = reg_hit(io_req.rd, hit, offset, RESULT_HIGH_OFFSET);

   // ****************************************
   // Control and status register.
   // ****************************************
   logic auto_trigger_enable;
   logic conversion_done_flag;
   logic result_lock;
   logic trig_edge;
   logic load_result;
   logic [2:0] trigger_source_select;

   // Enable, auto trigger, interrupt enable and prescale each have their own register; one write updates all four.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         converter_enable <= REG_RESET[CONV_EN_BIT];
      end else if (wr_ctrl) begin
         converter_enable <= io_req.wdata[CONV_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         auto_trigger_enable <= REG_RESET[AUTO_TRIG_BIT];
      end else if (wr_ctrl) begin
         auto_trigger_enable <= io_req.wdata[AUTO_TRIG_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable <= REG_RESET[IRQ_EN_BIT];
      end else if (wr_ctrl) begin
         irq_enable <= io_req.wdata[IRQ_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_select <= REG_RESET[PRESCALE_MSB:0];
      end else if (wr_ctrl) begin
         prescale_select <= io_req.wdata[PRESCALE_MSB:0];
      end
   end

   // ****************************************
   // Conversion start and busy.
   // ****************************************
   // Abort when the enable goes from one to zero.
   assign conv_abort = wr_ctrl && converter_enable && !io_req.wdata[CONV_EN_BIT];

   // Start request: software start bit or auto trigger edge.
   logic sw_start;
   assign sw_start = wr_ctrl && io_req.wdata[START_BIT] && io_req.wdata[CONV_EN_BIT];
   assign conv_start = !conv_abort && (sw_start || (trig_edge && converter_enable));

   // A start written together with the enable bit marks the core busy; only an abort outranks it.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_busy <= 1'b0;
      end else if (conv_abort) begin
         conv_busy <= 1'b0;
      end else if (conv_start) begin
         conv_busy <= 1'b1;
      end else if (conv_done || !converter_enable) begin
         conv_busy <= 1'b0;
      end
   end

   // ****************************************
   // Done flag.
   // ****************************************
   // Done flag: set wins over the write-one clear.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_done_flag <= 1'b0;
      end else if (conv_done && converter_enable) begin
         conversion_done_flag <= 1'b1;
      end else if (wr_ctrl && io_req.wdata[DONE_FLAG_BIT]) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // ****************************************
   // Special function register.
   // ****************************************
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigger_source_select <= REG_RESET[TRIG_SEL_MSB:TRIG_SEL_LSB];
      end else if (wr_sfr) begin
         trigger_source_select <= io_req.wdata[TRIG_SEL_MSB:TRIG_SEL_LSB];
      end
   end

   // ****************************************
   // Trigger source decode and edge detect.
   // ****************************************
   // Free running has no flag of its own, so it never yields a selection edge.
   function automatic logic select_flag(input logic [2:0] sel, input art_trig_flags_t f);
      logic v;
      case (art_trig_src_t'(sel))
         TRIG_FREE_RUN: v = 1'b0;
         TRIG_ANALOG_CMP: v = f.analog_cmp;
         TRIG_EXT_INT0: v = f.ext_int0;
         TRIG_T0_COMPARE: v = f.t0_compare;
         TRIG_T0_OVERFLOW: v = f.t0_overflow;
         TRIG_T1_COMPARE_B: v = f.t1_compare_b;
         TRIG_T1_OVERFLOW: v = f.t1_overflow;
         TRIG_T1_CAPTURE: v = f.t1_capture;
         default: v = 1'b0;
      endcase
      return v;
   endfunction : select_flag

   logic sel_flag;
   logic sel_flag_prev;
   logic free_run_edge;
   logic done_prev;
   assign sel_flag = select_flag(trigger_source_select, trig_flags);

   // The last selected flag makes a change of source look like a flag edge.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_flag_prev <= 1'b0;
      end else begin
         sel_flag_prev <= sel_flag;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_prev <= 1'b0;
      end else begin
         done_prev <= conversion_done_flag;
      end
   end

   // ****************************************
   // Trigger event.
   // ****************************************
   // Free running retriggers on a fresh completion, not on a source switch.
   assign free_run_edge = trigger_source_select == TRIG_FREE_RUN && conversion_done_flag
                          && !done_prev;
   assign trig_edge = auto_trigger_enable
                      && ((sel_flag && !sel_flag_prev) || free_run_edge);

   // ****************************************
   // Result registers.
   // ****************************************
   logic [9:0] result;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_lock <= 1'b0;
      end else if (rd_high) begin
         result_lock <= 1'b0;
      end else if (rd_low) begin
         result_lock <= 1'b1;
      end
   end

   // While frozen a new result is dropped, so both halves come from one conversion unless a result loads in the cycle of the low read.
   assign load_result = conv_done && converter_enable && !result_lock;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result <= RESULT_RESET;
      end else if (load_result) begin
         result <= conv_result;
      end
   end

   // ****************************************
   // Result views.
   // ****************************************
   logic [7:0] result_low_reg;
   logic [7:0] result_high_reg;
   always_comb begin
      if (left_align_select) begin
         result_low_reg = {result[1:0], 6'h00};
         result_high_reg = result[9:2];
      end else begin
         result_low_reg = result[7:0];
         result_high_reg = {6'h00, result[9:8]};
      end
   end

   // ****************************************
   // Read data.
   // ****************************************
   // Read data is registered and holds until the next valid read.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_rdata <= REG_RESET;
      end else if (io_req.rd && hit) begin
         case (offset)
            RESULT_LOW_OFFSET: io_rdata <= result_low_reg;
            RESULT_HIGH_OFFSET: io_rdata <= result_high_reg;
            CTRL_STATUS_OFFSET: io_rdata <= {converter_enable, conv_busy, auto_trigger_enable,
                                             conversion_done_flag, irq_enable, prescale_select};
            SPECIAL_FUNCTION_OFFSET: io_rdata <= {trigger_source_select, 5'h00};
            default: io_rdata <= REG_RESET;
         endcase
      end
   end
endmodule : art_result_trigger
`default_nettype wire

// ---- dv/art_result_trigger_assertions.sv ----
// Checker for the converter result and trigger block.
`timescale 1ns/1ps
`default_nettype none
module art_result_trigger_checker
   import art_pkg::*;
(
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic reset_n,
   // Watched signals.
   input wire art_io_req_t io_req,
   input wire logic [7:0] io_rdata,
   input wire logic left_align_select,
   input wire logic conv_done,
   input wire logic conv_start,
   input wire logic converter_enable,
   input wire logic conv_abort,
   input wire logic conv_busy
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   logic ctl_wr;
   logic rd_io;
   logic sfr_wr;
   assign ctl_wr = io_req.wr && io_req.addr == (io_req.data_space ? 8'h26 : 8'h06);
   assign sfr_wr = io_req.wr && io_req.addr == (io_req.data_space ? 8'h50 : 8'h30);
   assign rd_io = io_req.rd && !io_req.data_space;
   a_enable_follows: assert property (ctl_wr |=> converter_enable == $past(io_req.wdata[7]))
      else $error("enable bit not taken from write");
   a_abort_on_off: assert property (ctl_wr && !io_req.wdata[7] && converter_enable |-> conv_abort)
      else $error("no abort when converter switched off");
   a_abort_idles: assert property (conv_abort |=> !conv_busy && !converter_enable)
      else $error("busy or enable left after abort");
   a_start_busy: assert property (conv_start |=> conv_busy)
      else $error("start did not set busy");
   a_done_clears: assert property (conv_done && conv_busy && !conv_start |=> !conv_busy)
      else $error("busy not cleared by done");
   a_high_pad: assert property (rd_io && io_req.addr == 8'h05 && !left_align_select |=> io_rdata[7:2] == 6'h00)
      else $error("unused high bits not zero");
   a_low_pad: assert property (rd_io && io_req.addr == 8'h04 && left_align_select |=> io_rdata[5:0] == 6'h00)
      else $error("unused low bits not zero");
   a_bad_addr: assert property (rd_io && io_req.addr > 8'h3f |=> $stable(io_rdata))
      else $error("out of range read changed data");
   a_rdata_holds: assert property (!io_req.rd |=> $stable(io_rdata))
      else $error("read data changed without read");
   a_start_pulse: assert property (conv_start && !ctl_wr && !sfr_wr |=> !conv_start || ctl_wr)
      else $error("start longer than one cycle");
   c_start: cover property (conv_start);
   c_abort: cover property (conv_abort);
   c_done_busy: cover property (conv_done && conv_busy);
endmodule : art_result_trigger_checker
bind art_result_trigger art_result_trigger_checker art_result_trigger_checker_inst (.ref_clk, .reset_n,
   .io_req, .io_rdata, .left_align_select, .conv_done, .conv_start, .converter_enable, .conv_abort, .conv_busy);
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench for the converter result and trigger block.
`timescale 1ns/1ps
`default_nettype none
module tb
   import art_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   art_io_req_t io_req = '0;
   logic [7:0] io_rdata;
   logic left_align_select = 1'b0;
   art_trig_flags_t trig_flags = '0;
   logic conv_done = 1'b0;
   logic [9:0] conv_result = 10'h000;
   logic conv_start, converter_enable, conv_abort, conv_busy, ws_abort;
   logic [2:0] prescale_select;
   logic irq_enable;
   int errors = 0;
   int tests_run = 0;
   always #2.5 ref_clk = ~ref_clk;
   art_result_trigger art_result_trigger_inst (.ref_clk(ref_clk), .reset_n(reset_n), .io_req(io_req),
      .io_rdata(io_rdata), .left_align_select(left_align_select), .trig_flags(trig_flags),
      .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
      .converter_enable(converter_enable), .conv_abort(conv_abort), .conv_busy(conv_busy),
      .prescale_select(prescale_select), .irq_enable(irq_enable));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ds = 1'b0);
      @(posedge ref_clk) #1;
      io_req = '{addr: a, data_space: ds, rd: 1'b0, wr: 1'b1, wdata: d};
      #1 ws_abort = conv_abort;
      @(posedge ref_clk) #1;
      io_req.wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic ds, input logic [7:0] exp, input string what);
      @(posedge ref_clk) #1;
      io_req = '{addr: a, data_space: ds, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      @(posedge ref_clk) #1;
      io_req.rd = 1'b0;
      chk(io_rdata, exp, what);
   endtask : rd
   task automatic done(input logic [9:0] r);
      @(posedge ref_clk) #1;
      conv_done = 1'b1;
      conv_result = r;
      @(posedge ref_clk) #1;
      conv_done = 1'b0;
   endtask : done
   task automatic end_sim;
      $display("Checks run %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #50000;
      errors++;
      end_sim();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(8'h04, 1'b0, 8'h00, "low reset");
      rd(8'h05, 1'b0, 8'h00, "high reset");
      rd(8'h30, 1'b0, 8'h00, "select reset");
      wr(8'h06, 8'h80);
      done(10'h2d7);
      rd(8'h06, 1'b0, 8'h90, "done flag set");
      wr(8'h06, 8'h90);
      rd(8'h06, 1'b0, 8'h80, "done flag cleared");
      rd(8'h04, 1'b0, 8'hd7, "right low");
      rd(8'h05, 1'b0, 8'h02, "right high");
      left_align_select = 1'b1;
      rd(8'h04, 1'b0, 8'hc0, "left low");
      rd(8'h05, 1'b0, 8'hb5, "left high");
      left_align_select = 1'b0;
      rd(8'h04, 1'b0, 8'hd7, "low before freeze");
      done(10'h155);
      rd(8'h05, 1'b0, 8'h02, "frozen high");
      done(10'h3ff);
      rd(8'h04, 1'b0, 8'hff, "low after unfreeze");
      rd(8'h05, 1'b0, 8'h03, "high after unfreeze");
      wr(8'h04, 8'h00);
      wr(8'h05, 8'hff);
      rd(8'h04, 1'b0, 8'hff, "low after write");
      rd(8'h05, 1'b0, 8'h03, "high after write");
      wr(8'h50, 8'he0, 1'b1);
      rd(8'h30, 1'b0, 8'he0, "select via io");
      rd(8'h50, 1'b1, 8'he0, "select via data space");
      rd(8'h25, 1'b1, 8'h03, "high via data space");
      rd(8'h40, 1'b0, 8'h03, "out of range read");
      rd(8'h10, 1'b0, 8'h00, "unmapped read");
      @(posedge ref_clk) #1 trig_flags = 7'h7f;
      #1 chk(conv_start, 1'b0, "start without auto");
      @(posedge ref_clk) #1 trig_flags = 7'h00;
      wr(8'h06, 8'ha0);
      for (int c = 1; c < 8; c++) begin
         wr(8'h30, 8'(c << 5));
         @(posedge ref_clk) #1 trig_flags = 7'h7f ^ (7'h01 << (7 - c));
         #1 chk(conv_start, 1'b0, "other flags");
         @(posedge ref_clk) #1 trig_flags = 7'h7f;
         #1 chk(conv_start, 1'b1, "selected flag rise");
         @(posedge ref_clk) #1 trig_flags = 7'h00;
         done(10'h000);
      end
      wr(8'h30, 8'h40);
      @(posedge ref_clk) #1 trig_flags = 7'h40;
      wr(8'h30, 8'h20);
      chk(conv_start, 1'b1, "switch to set source");
      @(posedge ref_clk) #1 trig_flags = 7'h00;
      rd(8'h06, 1'b0, 8'hf0, "busy after trigger");
      done(10'h000);
      wr(8'h30, 8'h00);
      chk(conv_start, 1'b0, "switch to free running");
      wr(8'h06, 8'hb0);
      done(10'h000);
      chk(conv_start, 1'b1, "free running retrigger");
      wr(8'h30, 8'h20);
      @(posedge ref_clk) #1 trig_flags = 7'h40;
      wr(8'h06, 8'h00);
      chk(ws_abort, 1'b1, "abort on disable");
      chk(converter_enable, 1'b0, "enable off");
      rd(8'h06, 1'b0, 8'h10, "ctrl after abort");
      wr(8'h06, 8'h0d);
      chk(prescale_select, 8'h05, "prescale out");
      chk(irq_enable, 8'h01, "irq enable out");
      rd(8'h06, 1'b0, 8'h1d, "ctrl fields");
      end_sim();
   end
endmodule : tb
`default_nettype wire
